// *** core/cvs_pkg.sv ***
// shared constants, types and register map of the conversion control block
package cvs_pkg;
  localparam int        ADDR_W         = 8;
  localparam int        DATA_W         = 24;
  localparam int        ACC_W          = 36;
  localparam int        PERIOD_W       = 12;
  localparam int        SETTLE_W       = 4;
  // modulator runs at master clock / 16
  localparam logic [3:0] MOD_DIV_LAST  = 4'hF;
  // register byte addresses
  localparam logic [7:0] REG_MODE      = 8'h00;
  localparam logic [7:0] REG_FILTER    = 8'h04;
  localparam logic [7:0] REG_CHANNEL   = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0C;
  localparam logic [7:0] REG_DATA      = 8'h10;
  // filter register fields
  localparam int        FLT_PERIOD_LSB = 0;
  localparam int        FLT_CHOP_BIT   = 12;
  localparam int        FLT_QUICK_BIT  = 13;
  // status register fields
  localparam int        ST_READY_BIT   = 0;
  localparam int        ST_SETTLED_BIT = 1;
  localparam int        ST_MODE_LSB    = 2;
  // reset values
  localparam logic [2:0]          RST_MODE    = 3'h1;
  localparam logic [PERIOD_W-1:0] RST_PERIOD  = 12'h040;
  localparam logic                RST_CHOP    = 1'b1;
  localparam logic                RST_QUICK   = 1'b0;
  localparam logic [2:0]          RST_CHANNEL = 3'h0;
  // channel code that pairs the negative input with itself
  localparam logic [2:0]          CH_SHORT    = 3'h7;
  // full settling in output periods
  localparam logic [SETTLE_W-1:0] SETTLE_CHOP   = 4'h2;
  localparam logic [SETTLE_W-1:0] SETTLE_NOCHOP = 4'h3;

  typedef enum logic [2:0] {
    MODE_IDLE   = 3'b000,
    MODE_CONT   = 3'b001,
    MODE_SINGLE = 3'b010
  } cvs_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_HOLD   = 2'b01,
    ST_CONT   = 2'b10,
    ST_SINGLE = 2'b11
  } cvs_state_e;

  typedef struct packed {
    logic [PERIOD_W-1:0] period;
    logic                chop;
    logic                shortIn;
  } cvs_cfg_s;
endpackage

// *** core/cvs_filter.sv ***
// modulator divider, chopper and accumulate-and-dump filter
`timescale 1ns/1ps
module cvs_filter (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        hold,
  input  wire cvs_pkg::cvs_cfg_s           cfg,
  input  wire logic [cvs_pkg::DATA_W-1:0]  sample,
  output logic      [cvs_pkg::DATA_W-1:0]  resWord,
  output logic                             resStrobe,
  output logic                             settled
);
  logic [3:0]                      modCnt_q, modCnt_d;
  logic                            chopSign_q, chopSign_d;
  logic [cvs_pkg::PERIOD_W-1:0]    perCnt_q, perCnt_d;
  logic [cvs_pkg::ACC_W-1:0]       acc_q, acc_d;
  logic [cvs_pkg::SETTLE_W-1:0]    settleCnt_q, settleCnt_d;
  logic [cvs_pkg::DATA_W-1:0]      word_q, word_d;
  logic                            strobe_q, strobe_d;
  logic                            tick;
  logic                            periodEnd;
  logic [cvs_pkg::DATA_W-1:0]      inX, modX, demod;
  logic [cvs_pkg::ACC_W-1:0]       sum;
  logic [cvs_pkg::SETTLE_W-1:0]    need;

  always_comb begin
    tick      = (modCnt_q == cvs_pkg::MOD_DIV_LAST);
    inX       = cfg.shortIn ? '0 : sample;
    // chopped ahead of the first stage, undone after it, so offsets cancel
    modX      = chopSign_q ? (~inX + 24'h000001) : inX;
    demod     = chopSign_q ? (~modX + 24'h000001) : modX;
    sum       = acc_q + {{(cvs_pkg::ACC_W-cvs_pkg::DATA_W){demod[cvs_pkg::DATA_W-1]}}, demod};
    periodEnd = tick && (({1'b0, perCnt_q} + 13'h0001) >= {1'b0, cfg.period});
    need      = cfg.chop ? cvs_pkg::SETTLE_CHOP : cvs_pkg::SETTLE_NOCHOP;
    modCnt_d    = modCnt_q + 4'h1;
    chopSign_d  = chopSign_q;
    perCnt_d    = perCnt_q;
    acc_d       = acc_q;
    settleCnt_d = settleCnt_q;
    word_d      = word_q;
    strobe_d    = 1'b0;
    if (tick) begin
      chopSign_d = cfg.chop ? ~chopSign_q : 1'b0;
      perCnt_d   = perCnt_q + 12'h001;
      acc_d      = sum;
    end
    if (periodEnd) begin
      perCnt_d = '0;
      acc_d    = '0;
      word_d   = sum[cvs_pkg::ACC_W-1 -: cvs_pkg::DATA_W];
      strobe_d = 1'b1;
      if (settleCnt_q < need) begin
        settleCnt_d = settleCnt_q + 4'h1;
      end
    end
    // held: no samples gathered, counters and accumulator back to known zero, last word kept unless a period ends in the first held cycle
    if (hold) begin
      modCnt_d    = '0;
      chopSign_d  = 1'b0;
      perCnt_d    = '0;
      acc_d       = '0;
      settleCnt_d = '0;
      strobe_d    = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modCnt_q    <= '0;
      chopSign_q  <= 1'b0;
      perCnt_q    <= '0;
      acc_q       <= '0;
      settleCnt_q <= '0;
      word_q      <= '0;
      strobe_q    <= 1'b0;
    end else begin
      modCnt_q    <= modCnt_d;
      chopSign_q  <= chopSign_d;
      perCnt_q    <= perCnt_d;
      acc_q       <= acc_d;
      settleCnt_q <= settleCnt_d;
      word_q      <= word_d;
      strobe_q    <= strobe_d;
    end
  end

  assign resWord   = word_q;
  assign resStrobe = strobe_q;
  assign settled   = (settleCnt_q >= need);
endmodule

// *** core/cvs_conv_ctrl.sv ***
// conversion start, stop and restart control with register port
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module cvs_conv_ctrl (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        filterRestartN,
  input  wire logic [cvs_pkg::DATA_W-1:0]  modSample,
  input  wire logic [cvs_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [31:0]                 regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [31:0]                 regRdata,
  output logic                             resultReadyN,
  output logic                             filterSettledN,
  output logic                             clockOutputPin
);
  logic                          pinS1_q, pinS2_q, pinPrev_q;
  logic                          pinFall, pinRise, pinLow;
  cvs_pkg::cvs_state_e           state_q, state_d;
  logic [2:0]                    operatingModeField_q, operatingModeField_d;
  logic [cvs_pkg::PERIOD_W-1:0]  period_q, period_d;
  logic                          chopEnable_q, chopEnable_d;
  logic                          quickSettleEnable_q, quickSettleEnable_d;
  logic [2:0]                    channel_q, channel_d;
  logic [cvs_pkg::DATA_W-1:0]    data_q, data_d;
  logic                          readyN_q, readyN_d;
  logic [31:0]                   rdata_q, rdata_d;
  logic                          restart, filtHold, publish, stopSingle;
  logic                          wrMode, wrFilter, wrChannel, rdData;
  cvs_pkg::cvs_cfg_s             cfg;
  logic [cvs_pkg::DATA_W-1:0]    resWord;
  logic                          resStrobe, settled;

  // only the second stage and its one-cycle delayed copy feed the edge logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinS1_q   <= 1'b1;
      pinS2_q   <= 1'b1;
      pinPrev_q <= 1'b1;
    end else begin
      pinS1_q   <= filterRestartN;
      pinS2_q   <= pinS1_q;
      pinPrev_q <= pinS2_q;
    end
  end

  always_comb begin
    pinFall = pinPrev_q && !pinS2_q;
    pinRise = !pinPrev_q && pinS2_q;
    pinLow  = !pinS2_q;
  end

  always_comb begin
    wrMode    = regWr && (regAddr == cvs_pkg::REG_MODE);
    wrFilter  = regWr && (regAddr == cvs_pkg::REG_FILTER);
    wrChannel = regWr && (regAddr == cvs_pkg::REG_CHANNEL);
    rdData    = regRd && (regAddr == cvs_pkg::REG_DATA);
  end

  always_comb begin
    cfg.period  = period_q;
    cfg.chop    = chopEnable_q;
    cfg.shortIn = (channel_q == cvs_pkg::CH_SHORT);
  end

  // main sequencing
  always_comb begin
    state_d              = state_q;
    operatingModeField_d = operatingModeField_q;
    restart              = 1'b0;
    publish              = 1'b0;
    stopSingle           = 1'b0;
    unique case (state_q)
      cvs_pkg::ST_IDLE: begin
      end
      cvs_pkg::ST_HOLD: begin
        if (pinRise) begin
          restart = 1'b1;
          state_d = (operatingModeField_q == cvs_pkg::MODE_CONT) ?
                    cvs_pkg::ST_CONT : cvs_pkg::ST_SINGLE;
        end
      end
      cvs_pkg::ST_CONT: begin
        publish = resStrobe && settled;
      end
      cvs_pkg::ST_SINGLE: begin
        // quick settle shows early words while the filter still settles
        publish    = resStrobe && (settled || quickSettleEnable_q);
        stopSingle = resStrobe && settled;
        if (stopSingle) begin
          state_d              = cvs_pkg::ST_IDLE;
          operatingModeField_d = cvs_pkg::MODE_IDLE;
        end
      end
    endcase
    if (wrMode) begin
      // software write wins over the automatic return to idle
      operatingModeField_d = regWdata[2:0];
      restart = 1'b1;
      unique case (regWdata[2:0])
        cvs_pkg::MODE_CONT:   state_d = cvs_pkg::ST_CONT;
        cvs_pkg::MODE_SINGLE: state_d = cvs_pkg::ST_SINGLE;
        default:              state_d = cvs_pkg::ST_IDLE;
      endcase
    end
    if (pinFall || (pinLow && !pinRise)) begin
      state_d = cvs_pkg::ST_HOLD;
      restart = 1'b0;
      publish = 1'b0;
    end
  end

  always_comb begin
    filtHold = restart || (state_q == cvs_pkg::ST_IDLE)
                       || (state_q == cvs_pkg::ST_HOLD);
  end

  // setup registers: only software writes change them
  always_comb begin
    period_d            = period_q;
    chopEnable_d        = chopEnable_q;
    quickSettleEnable_d = quickSettleEnable_q;
    channel_d           = channel_q;
    if (wrFilter) begin
      period_d            = regWdata[cvs_pkg::FLT_PERIOD_LSB +: cvs_pkg::PERIOD_W];
      chopEnable_d        = regWdata[cvs_pkg::FLT_CHOP_BIT];
      quickSettleEnable_d = regWdata[cvs_pkg::FLT_QUICK_BIT];
    end
    if (wrChannel) begin
      channel_d = regWdata[2:0];
    end
  end

  // data word and ready flag
  always_comb begin
    data_d   = data_q;
    readyN_d = readyN_q;
    if (rdData || restart || (state_d == cvs_pkg::ST_HOLD)) begin
      readyN_d = 1'b1;
    end
    if (publish) begin
      data_d   = resWord;
      readyN_d = 1'b0;
    end
  end

  always_comb begin
    rdata_d = 32'h00000000;
    if (regRd) begin
      unique case (regAddr)
        cvs_pkg::REG_MODE:    rdata_d[2:0] = operatingModeField_q;
        cvs_pkg::REG_FILTER: begin
          rdata_d[cvs_pkg::FLT_PERIOD_LSB +: cvs_pkg::PERIOD_W] = period_q;
          rdata_d[cvs_pkg::FLT_CHOP_BIT]  = chopEnable_q;
          rdata_d[cvs_pkg::FLT_QUICK_BIT] = quickSettleEnable_q;
        end
        cvs_pkg::REG_CHANNEL: rdata_d[2:0] = channel_q;
        cvs_pkg::REG_STATUS: begin
          rdata_d[cvs_pkg::ST_READY_BIT]   = readyN_q;
          rdata_d[cvs_pkg::ST_SETTLED_BIT] = !settled;
          rdata_d[cvs_pkg::ST_MODE_LSB +: 3] = operatingModeField_q;
        end
        cvs_pkg::REG_DATA:    rdata_d[cvs_pkg::DATA_W-1:0] = data_q;
        default:              rdata_d = 32'h00000000;
      endcase
    end
  end

  // synchronous reset: accesses during it change nothing and read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q              <= cvs_pkg::ST_CONT;
      operatingModeField_q <= cvs_pkg::RST_MODE;
      period_q             <= cvs_pkg::RST_PERIOD;
      chopEnable_q         <= cvs_pkg::RST_CHOP;
      quickSettleEnable_q  <= cvs_pkg::RST_QUICK;
      channel_q            <= cvs_pkg::RST_CHANNEL;
      data_q               <= '0;
      readyN_q             <= 1'b1;
      rdata_q              <= 32'h00000000;
    end else begin
      state_q              <= state_d;
      operatingModeField_q <= operatingModeField_d;
      period_q             <= period_d;
      chopEnable_q         <= chopEnable_d;
      quickSettleEnable_q  <= quickSettleEnable_d;
      channel_q            <= channel_d;
      data_q               <= data_d;
      readyN_q             <= readyN_d;
      rdata_q              <= rdata_d;
    end
  end

  cvs_filter u_filter (
    .clk       (clk),
    .rst_n     (rst_n),
    .hold      (filtHold),
    .cfg       (cfg),
    .sample    (modSample),
    .resWord   (resWord),
    .resStrobe (resStrobe),
    .settled   (settled)
  );

  assign regRdata       = rdata_q;
  assign resultReadyN   = readyN_q;
  assign filterSettledN = !settled;
  // forwarded straight through, so it keeps running during reset
  assign clockOutputPin = clk;

  a_fall_enters_hold: assert property (@(posedge clk) disable iff (!rst_n)
    pinFall |=> (state_q == cvs_pkg::ST_HOLD) && readyN_q)
    else $error("restart fall did not enter hold");

  a_hold_no_samples: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == cvs_pkg::ST_HOLD) |-> filtHold && !publish)
    else $error("filter ran while held");

  a_release_runs: assert property (@(posedge clk) disable iff (!rst_n)
    (pinRise && state_q == cvs_pkg::ST_HOLD && !regWr) |=> !filtHold)
    else $error("filter not released one cycle after rise");

  a_setup_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (pinFall || pinRise) && !regWr |=> $stable(period_q) && $stable(chopEnable_q)
      && $stable(channel_q) && $stable(quickSettleEnable_q))
    else $error("restart pin changed setup");

  a_release_latency: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pinS2_q) && state_q == cvs_pkg::ST_HOLD && !regWr
      |-> restart ##1 (state_q != cvs_pkg::ST_HOLD))
    else $error("release latency not fixed");

  a_ready_falls: assert property (@(posedge clk) disable iff (!rst_n)
    publish |=> !readyN_q && (data_q == $past(resWord)))
    else $error("ready did not fall with new data");

  a_full_settle: assert property (@(posedge clk) disable iff (!rst_n)
    publish && !(quickSettleEnable_q && state_q == cvs_pkg::ST_SINGLE) |-> settled)
    else $error("data published before settling");

  a_single_idles: assert property (@(posedge clk) disable iff (!rst_n)
    stopSingle && !wrMode && !pinLow |=> state_q == cvs_pkg::ST_IDLE
      && operatingModeField_q == cvs_pkg::MODE_IDLE)
    else $error("single conversion did not return to idle");

  a_quick_stops: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == cvs_pkg::ST_SINGLE) && resStrobe && !settled && !pinLow && !wrMode
      |=> state_q == cvs_pkg::ST_SINGLE)
    else $error("single mode stopped before settling");

  a_reset_state: assert property (@(posedge clk)
    !rst_n |=> readyN_q && regRdata == 32'h00000000
      && operatingModeField_q == cvs_pkg::RST_MODE)
    else $error("reset did not restore defaults");
endmodule

// *** tb/cvs_host_model.sv ***
// host side model: drives the restart pin and feeds modulator samples
`timescale 1ns/1ps
module cvs_host_model (
  input  wire logic                       clk,
  output logic                            filterRestartN,
  output logic      [cvs_pkg::DATA_W-1:0] modSample
);
  initial begin
    filterRestartN = 1'b1;
    modSample      = 24'h012345;
  end

  // samples keep moving so a stuck input path cannot pass for a shorted one
  always @(posedge clk) begin
    modSample <= modSample + 24'h000F31;
  end

  // no calibration is ever issued mid-run by this host
  // pin edges are launched right after a clock edge and held for whole cycles
  task automatic restart_low();
    @(posedge clk);
    filterRestartN <= 1'b0;
  endtask

  task automatic restart_high();
    @(posedge clk);
    filterRestartN <= 1'b1;
  endtask
endmodule

// *** tb/cvs_conv_ctrl_test.sv ***
// self-checking bench of the conversion start, stop and restart control
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module cvs_conv_ctrl_test;
  logic        clk;
  logic        rst_n;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        resultReadyN;
  logic        filterSettledN;
  logic        clockOutputPin;
  logic        filterRestartN;
  logic [23:0] modSample;
  int          mismatches;
  int          checked;
  int          lat;
  int          firstLat;
  int          lowSeen;

  cvs_host_model host (
    .clk            (clk),
    .filterRestartN (filterRestartN),
    .modSample      (modSample)
  );

  cvs_conv_ctrl dut (
    .clk            (clk),
    .rst_n          (rst_n),
    .filterRestartN (filterRestartN),
    .modSample      (modSample),
    .regAddr        (regAddr),
    .regWdata       (regWdata),
    .regWr          (regWr),
    .regRd          (regRd),
    .regRdata       (regRdata),
    .resultReadyN   (resultReadyN),
    .filterSettledN (filterSettledN),
    .clockOutputPin (clockOutputPin)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic chkrd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    `CHK("regRdata", exp, regRdata)
  endtask

  // counts edges until ready falls, bounded so a dead block cannot hang
  task automatic wait_rdy(output int n);
    n = 0;
    // step off the launching edge so a ready still low from before is not taken
    #1;
    while (resultReadyN !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic count_low(input int cycles, output int lows);
    lows = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (resultReadyN !== 1'b1) lows++;
    end
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #200us;
    mismatches++;
    final_report();
  end

  initial begin
    mismatches = 0;
    checked    = 0;
    rst_n      = 1'b0;
    regAddr    = 8'h00;
    regWdata   = 32'h00000000;
    regWr      = 1'b0;
    regRd      = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // defaults after reset, unmapped address reads zero
    chkrd(cvs_pkg::REG_MODE, 32'h00000001);
    chkrd(cvs_pkg::REG_FILTER, 32'h00001040);
    chkrd(cvs_pkg::REG_CHANNEL, 32'h00000000);
    chkrd(cvs_pkg::REG_DATA, 32'h00000000);
    chkrd(cvs_pkg::REG_STATUS, 32'h00000007);
    chkrd(8'h14, 32'h00000000);
    // default period 0x40 ticks of 16 clocks, settled after two words
    wait_rdy(lat);
    `CHK("defaultSettle", 1'b1, (lat >= 2030 && lat <= 2200))
    // host sets up again after reset: short period, shorted input
    wr(cvs_pkg::REG_FILTER, 32'h00001004);
    wr(cvs_pkg::REG_CHANNEL, 32'h00000007);
    wr(cvs_pkg::REG_MODE, 32'h00000001);
    wait_rdy(lat);
    `CHK("chopSettle", 1'b1, (lat >= 124 && lat <= 200))
    chkrd(cvs_pkg::REG_DATA, 32'h00000000);
    // restart pin twice: hold, release, equal latency both times
    for (int i = 0; i < 2; i++) begin
      host.restart_low();
      repeat (4) @(posedge clk);
      wr(cvs_pkg::REG_MODE, 32'h00000001);
      count_low(300, lowSeen);
      `CHK("holdReady", 0, lowSeen)
      host.restart_high();
      wait_rdy(lat);
      `CHK("releaseLat", 1'b1, (lat >= 124 && lat <= 200))
      if (i == 0) firstLat = lat;
    end
    `CHK("latMatch", firstLat, lat)
    chkrd(cvs_pkg::REG_FILTER, 32'h00001004);
    chkrd(cvs_pkg::REG_CHANNEL, 32'h00000007);
    // mode 0,0,0 written while running stops all conversions
    wr(cvs_pkg::REG_MODE, 32'h00000000);
    count_low(150, lowSeen);
    `CHK("idleByWrite", 0, lowSeen)
    // single conversion by mode write, chop off: three words to settle
    wr(cvs_pkg::REG_FILTER, 32'h00000004);
    wr(cvs_pkg::REG_MODE, 32'h00000002);
    wait_rdy(lat);
    `CHK("singleSettle", 1'b1, (lat >= 188 && lat <= 270))
    repeat (2) @(posedge clk);
    chkrd(cvs_pkg::REG_MODE, 32'h00000000);
    chkrd(cvs_pkg::REG_DATA, 32'h00000000);
    count_low(300, lowSeen);
    `CHK("idleQuiet", 0, lowSeen)
    // pin release in idle starts one conversion
    host.restart_low();
    repeat (6) @(posedge clk);
    host.restart_high();
    wait_rdy(lat);
    `CHK("pinSingle", 1'b1, (lat >= 188 && lat <= 270))
    repeat (2) @(posedge clk);
    chkrd(cvs_pkg::REG_MODE, 32'h00000000);
    // quick settle: an early unsettled word, stop only once settled
    wr(cvs_pkg::REG_FILTER, 32'h00002004);
    wr(cvs_pkg::REG_MODE, 32'h00000002);
    wait_rdy(lat);
    `CHK("quickEarly", 1'b1, (lat >= 60 && lat <= 140))
    `CHK("quickUnsettled", 1'b1, filterSettledN)
    chkrd(cvs_pkg::REG_MODE, 32'h00000002);
    lat = 0;
    while (filterSettledN !== 1'b0 && lat < 400) begin
      @(posedge clk);
      #1;
      lat++;
    end
    `CHK("quickSettled", 1'b0, filterSettledN)
    repeat (4) @(posedge clk);
    chkrd(cvs_pkg::REG_MODE, 32'h00000000);
    // second reset mid-run: writes ignored, ready high, clock forwarded
    @(posedge clk);
    rst_n <= 1'b0;
    wr(cvs_pkg::REG_CHANNEL, 32'h00000005);
    @(posedge clk);
    #1;
    `CHK("resetReady", 1'b1, resultReadyN)
    `CHK("clkOutHigh", clk, clockOutputPin)
    @(negedge clk);
    #1;
    `CHK("clkOutLow", clk, clockOutputPin)
    @(posedge clk);
    rst_n <= 1'b1;
    chkrd(cvs_pkg::REG_CHANNEL, 32'h00000000);
    chkrd(cvs_pkg::REG_FILTER, 32'h00001040);
    final_report();
  end
endmodule
